//--- rtl/tko_output_control.sv
// Touch key output control: strap decode, press limit, low-power timer, output drive
`timescale 1ns/10ps
module tko_output_control
	import tko_pkg::*;
#(
	parameter longint unsigned PRESS_LIMIT = PRESS_LIMIT_CYCLES,
	parameter longint unsigned IDLE_LIMIT  = IDLE_CYCLES,
	parameter longint unsigned FAST_RESP   = FAST_RESP_CYCLES,
	parameter longint unsigned SLOW_RESP   = LOW_POWER_RESP_CYCLES
) (
	input  wire logic           clk,
	input  wire logic           resetn,
	input  wire logic           touch_detect,
	input  wire tko_straps_type straps,
	output logic                touch_out,
	output tko_status_type      status
);

	// ==========================================================
	// Input synchronisers: three stages, change accepted when stages 2 and 3 agree
	logic [2:0] touch_sync_reg;
	logic [2:0] lvl_sync_reg;
	logic [2:0] mode_sync_reg;
	logic       touch_reg;
	logic       level_reg;
	logic       mode_reg;

	// Strap value the level register takes next, so the pin flop can follow it in step
	wire        level_next = (lvl_sync_reg[1] == lvl_sync_reg[2]) ? lvl_sync_reg[2] : level_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			touch_sync_reg <= 3'h0;
			lvl_sync_reg   <= 3'h0;
			mode_sync_reg  <= 3'h0;
		end else begin
			touch_sync_reg <= {touch_sync_reg[1:0], touch_detect};
			lvl_sync_reg   <= {lvl_sync_reg[1:0], straps.level_select_strap};
			mode_sync_reg  <= {mode_sync_reg[1:0], straps.output_mode_strap};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			touch_reg <= 1'b0;
			level_reg <= 1'b0;
			mode_reg  <= 1'b0;
		end else begin
			if (touch_sync_reg[1] == touch_sync_reg[2])
				touch_reg <= touch_sync_reg[2];
			level_reg <= level_next;
			if (mode_sync_reg[1] == mode_sync_reg[2])
				mode_reg <= mode_sync_reg[2];
		end
	end

	// ==========================================================
	// Press sampling: touch is taken after the response delay of the current power mode
	logic [CNT_W-1:0] resp_cnt_reg;
	logic [CNT_W-1:0] press_cnt_reg;
	logic [CNT_W-1:0] idle_cnt_reg;
	logic             pressed_reg;
	logic             low_power_reg;
	logic             out_state_reg;
	logic             need_release_reg;

	// Counters stop one short of the limit so the action lands on the limit-th edge
	function automatic logic count_reached(input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] limit);
		return cnt >= limit - CNT_W'(1);
	endfunction

	wire [CNT_W-1:0] resp_limit = low_power_reg ? CNT_W'(SLOW_RESP) : CNT_W'(FAST_RESP);
	wire             resp_done   = count_reached(resp_cnt_reg, resp_limit);
	wire             pressed_next = touch_reg ? (pressed_reg | resp_done) : 1'b0;
	wire             new_press    = pressed_next & ~pressed_reg & ~need_release_reg;
	wire             toggle_mode  = mode_reg;
	wire             timeout = ~toggle_mode & pressed_reg & ~need_release_reg
		& count_reached(press_cnt_reg, CNT_W'(PRESS_LIMIT));
	wire             idle_done = count_reached(idle_cnt_reg, CNT_W'(IDLE_LIMIT));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			resp_cnt_reg <= '0;
		else if (!touch_reg || pressed_reg)
			resp_cnt_reg <= '0;
		else
			resp_cnt_reg <= resp_cnt_reg + 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			pressed_reg <= 1'b0;
		else
			pressed_reg <= pressed_next;
	end

	// Timeout acts as a power-up restart; only a release re-arms detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			need_release_reg <= 1'b0;
		else if (timeout)
			need_release_reg <= 1'b1;
		else if (!touch_reg)
			need_release_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			press_cnt_reg <= '0;
		else if (timeout || need_release_reg || !pressed_reg || toggle_mode)
			press_cnt_reg <= '0;
		else
			press_cnt_reg <= press_cnt_reg + 1'b1;
	end

	// ==========================================================
	// Power mode: low power after idle time, fast again once a touch is taken
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			idle_cnt_reg  <= '0;
			low_power_reg <= LOW_POWER_RESET;
		end else if (timeout) begin
			idle_cnt_reg  <= '0;
			low_power_reg <= LOW_POWER_RESET;
		end else if (touch_reg) begin
			// Stay slow until the press is taken, or waking would cut the slow response short
			idle_cnt_reg  <= '0;
			if (pressed_next)
				low_power_reg <= 1'b0;
		end else if (idle_done) begin
			low_power_reg <= 1'b1;
		end else begin
			idle_cnt_reg  <= idle_cnt_reg + 1'b1;
		end
	end

	// ==========================================================
	// Output state
	wire out_state_next = timeout ? OUT_STATE_RESET
		: toggle_mode ? (out_state_reg ^ new_press)
		: (pressed_next & ~need_release_reg);

	// Pin is its own flop, fed from next state and next strap so it never lags the state
	logic touch_out_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_state_reg <= OUT_STATE_RESET;
			touch_out_reg <= OUT_STATE_RESET;
		end else begin
			out_state_reg <= out_state_next;
			touch_out_reg <= out_state_next ^ level_next;
		end
	end

	// Polarity applied after the state so a level strap change never flips the held state
	assign touch_out = touch_out_reg;
	assign status    = '{out_state: out_state_reg, low_power: low_power_reg};

	// ==========================================================
	// Assertions
	AST_POLARITY: assert property (@(posedge clk) disable iff (!resetn)
		touch_out == (level_reg ? ~out_state_reg : out_state_reg))
		else $error("Output polarity does not follow level strap");

	AST_SYNC_FOLLOW: assert property (@(posedge clk) disable iff (!resetn)
		!toggle_mode && !touch_reg |=> !out_state_reg)
		else $error("Synchronous output active without touch");

	AST_TOGGLE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		toggle_mode && $past(toggle_mode) && !touch_reg && !timeout
		|=> $stable(out_state_reg))
		else $error("Toggle output changed without a new touch");

	AST_TOGGLE_FLIP: assert property (@(posedge clk) disable iff (!resetn)
		toggle_mode && new_press |=> out_state_reg != $past(out_state_reg))
		else $error("Toggle output did not invert on new touch");

	AST_PRESS_LIMIT: assert property (@(posedge clk) disable iff (!resetn)
		press_cnt_reg < CNT_W'(PRESS_LIMIT))
		else $error("Press timer ran past its limit");

	AST_TIMEOUT_RESET: assert property (@(posedge clk) disable iff (!resetn)
		timeout |=> !out_state_reg && !low_power_reg && press_cnt_reg == '0)
		else $error("Timeout did not restore power-up state");

	AST_HOLD_OFF: assert property (@(posedge clk) disable iff (!resetn)
		need_release_reg && touch_reg |=> !out_state_reg || toggle_mode)
		else $error("Output asserted before a new detection after timeout");

	AST_LOW_POWER_WAKE: assert property (@(posedge clk) disable iff (!resetn)
		pressed_next |=> !low_power_reg)
		else $error("Taken touch did not restore fast mode");

	AST_IDLE_RESTART: assert property (@(posedge clk) disable iff (!resetn)
		touch_reg |=> idle_cnt_reg == '0)
		else $error("Touch activity did not restart the idle timer");

	AST_SLOW_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		low_power_reg && touch_reg && !pressed_next |=> low_power_reg)
		else $error("Low power left before the slow response was taken");

	AST_PRESS_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
		need_release_reg |-> press_cnt_reg == '0)
		else $error("Press timer ran after a timeout");

	AST_RESPONSE: assert property (@(posedge clk) disable iff (!resetn)
		resp_cnt_reg <= CNT_W'(SLOW_RESP))
		else $error("Response delay exceeded its bound");

	COV_SYNC_PRESS: cover property (@(posedge clk) disable iff (!resetn)
		!toggle_mode && new_press);
	COV_TOGGLE: cover property (@(posedge clk) disable iff (!resetn)
		toggle_mode && new_press);
	COV_TIMEOUT: cover property (@(posedge clk) disable iff (!resetn) timeout);
	COV_LOW_POWER: cover property (@(posedge clk) disable iff (!resetn)
		$rose(low_power_reg));

endmodule

//--- rtl/tko_pkg.sv
// Package: constants and carrier types for the touch key output control block
package tko_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS           = 10;
	localparam int unsigned PRESS_LIMIT_S           = 9;
	localparam int unsigned IDLE_TO_LOW_POWER_TIME_S = 12;
	localparam int unsigned FAST_RESPONSE_MS        = 70;
	localparam int unsigned LOW_POWER_RESPONSE_MS   = 160;
	localparam longint unsigned PRESS_LIMIT_CYCLES =
		longint'(PRESS_LIMIT_S) * 64'h3b9aca00 / CLK_PERIOD_NS;
	localparam longint unsigned IDLE_CYCLES =
		longint'(IDLE_TO_LOW_POWER_TIME_S) * 64'h3b9aca00 / CLK_PERIOD_NS;
	localparam longint unsigned FAST_RESP_CYCLES =
		longint'(FAST_RESPONSE_MS) * 64'hf4240 / CLK_PERIOD_NS;
	localparam longint unsigned LOW_POWER_RESP_CYCLES =
		longint'(LOW_POWER_RESPONSE_MS) * 64'hf4240 / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 32;

	// ==========================================================
	// Reset values
	localparam logic OUT_STATE_RESET = 1'b0;
	localparam logic LOW_POWER_RESET = 1'b0;

	// ==========================================================
	// Types
	typedef struct packed {
		logic level_select_strap;
		logic output_mode_strap;
	} tko_straps_type;

	typedef struct packed {
		logic out_state;
		logic low_power;
	} tko_status_type;

endpackage

//--- sim/tko_host_model.sv
// Host-side model that reads the touch output pin
`timescale 1ns/10ps
module tko_host_model (
	input  wire logic touch_out,
	input  wire logic level_select_strap,
	output logic      host_active
);
	// Host knows the strap wiring and undoes the pin polarity
	assign host_active = touch_out ^ level_select_strap;
endmodule

//--- sim/tb_touch_key_output_control.sv
// Self-checking testbench for the touch key output control block
`timescale 1ns/10ps
module tb_touch_key_output_control import tko_pkg::*; ();
	// Short counts keep the run small
	localparam int PL = 200, IL = 300, FR = 5, SR = 12;
	logic           clk, resetn, touch_detect, touch_out, host_active;
	tko_straps_type straps;
	tko_status_type status;
	int             n_errors, check_count, n, exp_state;

	tko_output_control #(.PRESS_LIMIT(PL), .IDLE_LIMIT(IL), .FAST_RESP(FR), .SLOW_RESP(SR))
	dut_u (.clk(clk), .resetn(resetn), .touch_detect(touch_detect), .straps(straps),
		.touch_out(touch_out), .status(status));
	tko_host_model host_u (.touch_out(touch_out),
		.level_select_strap(straps.level_select_strap), .host_active(host_active));

	// ==========================================================
	// Checks and report
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Model state against state flag and pin
	task automatic cmp();
		chk(status.out_state === exp_state[0], "state mismatch");
		chk(touch_out === (exp_state[0] ^ straps.level_select_strap), "pin mismatch");
	endtask
	task automatic wait_out(input logic lvl, input int bound);
		n = 0;
		while (host_active !== lvl && n < bound) begin
			@(negedge clk);
			n++;
		end
		if (host_active !== lvl) begin
			chk(1'b0, "output wait timed out");
			end_of_test();
		end
	endtask

	// ==========================================================
	// Stimulus
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		resetn = 1'b0;
		touch_detect = 1'b0;
		straps = '0;
		exp_state = 0;
		void'($urandom(32'h1af6));
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		for (int lv = 0; lv < 2; lv++) begin
			straps.level_select_strap = lv[0];
			repeat (6) @(negedge clk);
			cmp();
			touch_detect = 1'b1;
			wait_out(1'b1, FR + 12);
			exp_state = 1;
			chk(n >= FR && n <= FR + 10, "fast response");
			cmp();
			touch_detect = 1'b0;
			wait_out(1'b0, 12);
			exp_state = 0;
			cmp();
		end
		// A touch shorter than the response delay is dropped
		touch_detect = 1'b1;
		repeat (FR - 2) @(negedge clk);
		touch_detect = 1'b0;
		repeat (15) @(negedge clk);
		cmp();
		straps.output_mode_strap = 1'b1;
		repeat (6) @(negedge clk);
		repeat (2) begin
			touch_detect = 1'b1;
			wait_out(~exp_state[0], FR + 12);
			exp_state ^= 1;
			// Toggle mode has no press limit
			repeat (PL + 50) @(negedge clk);
			cmp();
			touch_detect = 1'b0;
			repeat ($urandom_range(8, 30)) @(negedge clk);
			cmp();
		end
		straps.output_mode_strap = 1'b0;
		repeat (6) @(negedge clk);
		touch_detect = 1'b1;
		wait_out(1'b1, FR + 12);
		wait_out(1'b0, PL + 20);
		chk(n >= PL - FR - 12 && n <= PL, "press limit");
		repeat (40) @(negedge clk);
		cmp();
		chk(status.low_power === 1'b0, "timeout power mode");
		touch_detect = 1'b0;
		repeat ($urandom_range(6, 12)) @(negedge clk);
		touch_detect = 1'b1;
		wait_out(1'b1, FR + 12);
		exp_state = 1;
		cmp();
		touch_detect = 1'b0;
		wait_out(1'b0, 12);
		exp_state = 0;
		repeat (IL - 20) @(negedge clk);
		chk(status.low_power === 1'b0, "early low power");
		repeat (40) @(negedge clk);
		chk(status.low_power === 1'b1, "no low power");
		touch_detect = 1'b1;
		wait_out(1'b1, SR + 12);
		chk(n >= SR && n <= SR + 10, "slow response");
		chk(status.low_power === 1'b0, "no wake");
		touch_detect = 1'b0;
		wait_out(1'b0, 12);
		// Mid-run reset from an active toggle state gives the power-up state
		straps.output_mode_strap = 1'b1;
		repeat (6) @(negedge clk);
		touch_detect = 1'b1;
		wait_out(1'b1, FR + 12);
		exp_state = 1;
		cmp();
		resetn = 1'b0;
		touch_detect = 1'b0;
		@(negedge clk);
		chk(status === 2'h0 && touch_out === 1'b0, "reset state");
		resetn = 1'b1;
		exp_state = 0;
		repeat (6) @(negedge clk);
		cmp();
		chk(status.low_power === 1'b0, "reset power mode");
		end_of_test();
	end
endmodule
